// file: nio_board_model.sv
// board model for the port pins: external drivers, board pull-ups and floating lines
`timescale 1ns/100ps
module nio_board_model #(
  parameter int W = 34,
  parameter logic [W-1:0] OD_MASK = '0,
  parameter logic [W-1:0] BOARD_PU = '0
) (
  input wire logic clk_sys,
  input wire logic [W-1:0] drv_out,
  input wire logic [W-1:0] drv_oe,
  input wire logic [W-1:0] chip_pu,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_lvl
);
  // an undriven line with no pull-up wanders, so nobody may rely on its last value
  logic [W-1:0] float_pat = '0;

  always_ff @(posedge clk_sys) begin
    float_pat <= ~float_pat;
  end

  // chip drive wins over the board; open-drain bits only ever sink
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (drv_oe[k]) begin
        pin_lvl[k] = OD_MASK[k] ? 1'b0 : drv_out[k];
      end else if (ext_en[k]) begin
        pin_lvl[k] = ext_val[k];
      end else if (chip_pu[k] || BOARD_PU[k]) begin
        pin_lvl[k] = 1'b1;
      end else begin
        pin_lvl[k] = float_pat[k];
      end
    end
  end
endmodule : nio_board_model

// file: nio_noise_filter.sv
// noise eliminator: passes a level only after it holds for a fixed time
`timescale 1ns/100ps
module nio_noise_filter (
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  input wire logic raw_in,
  output logic clean_out
);
  logic clean_reg;
  logic [nio_pkg::FILT_CNT_W-1:0] cnt_reg;
  logic differs;
  logic expired;

  // a differing level must persist for the whole window before it is taken
  assign differs = raw_in != clean_reg;
  assign expired = cnt_reg == nio_pkg::FILT_CNT_W'(nio_pkg::FILT_CYCLES - 1);
  assign clean_out = clean_reg;

  // any return to the held level restarts the window, so short glitches die
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clean_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (!differs) begin
      cnt_reg <= '0;
    end else if (expired) begin
      clean_reg <= raw_in;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : nio_noise_filter

// file: nio_pin_group.sv
// driver stage for one port: registered pin drive and read-back selection
`timescale 1ns/100ps
module nio_pin_group #(
  parameter int W = 4,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] rd_val
);
  logic [W-1:0] out_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] out_next;
  logic [W-1:0] oe_next;

  // open drain only ever sinks: a one in the latch releases the pin
  assign out_next = OPEN_DRAIN ? '0 : latch;
  assign oe_next = OPEN_DRAIN ? ~latch : dir;
  // output bits read back their latch, inputs and open-drain read the wire
  assign rd_val = OPEN_DRAIN ? pin_in : ((dir & latch) | (~dir & pin_in));
  assign pin_out = out_reg;
  assign pin_oe = oe_reg;

  // drive registered so every top output comes from a flip-flop
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_reg <= '0;
      oe_reg <= '0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end
endmodule : nio_pin_group

// file: nio_pkg.sv
// shared constants for the nibble port set: register map, fields, resets, timing
package nio_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_NIB_A = 8'h00;
  localparam logic [7:0] OFS_NIB_B = 8'h04;
  localparam logic [7:0] OFS_NIB_C = 8'h08;
  localparam logic [7:0] OFS_NIB_D = 8'h0C;
  localparam logic [7:0] OFS_NIB_E = 8'h10;
  localparam logic [7:0] OFS_NIB_F = 8'h14;
  localparam logic [7:0] OFS_NIB_G = 8'h18;
  localparam logic [7:0] OFS_NIB_H = 8'h1C;
  localparam logic [7:0] OFS_PAIR_I = 8'h20;
  localparam logic [7:0] OFS_DIR = 8'h24;
  localparam logic [7:0] OFS_PULLUP = 8'h28;
  localparam logic [7:0] OFS_FILTER = 8'h2C;
  // direction register fields
  localparam int DIR_D_LSB = 0;
  localparam int DIR_G_LSB = 4;
  localparam int DIR_C_BIT = 8;
  localparam int DIR_H_BIT = 9;
  localparam int DIR_I_BIT = 10;
  localparam int DIR_W = 11;
  // pull-up group register fields, one bit per group
  localparam int PU_A_BIT = 0;
  localparam int PU_B_BIT = 1;
  localparam int PU_C_BIT = 2;
  localparam int PU_D_BIT = 3;
  localparam int PU_G_BIT = 4;
  localparam int PU_H_BIT = 5;
  localparam int PU_I_BIT = 6;
  localparam int PU_W = 7;
  // filter register field
  localparam int FILT_EN_BIT = 0;
  // reset values
  localparam logic [3:0] RST_OD_LATCH = 4'hF;
  localparam logic [3:0] RST_PP_LATCH = 4'h0;
  localparam logic [1:0] RST_PAIR_LATCH = 2'h0;
  localparam logic [DIR_W-1:0] RST_DIR = 11'h000;
  localparam logic [PU_W-1:0] RST_PULLUP = 7'h00;
  localparam logic RST_FILT_EN = 1'b0;
  // noise filter timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_TIME_NS = 40;
  localparam int FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W = 3;
endpackage : nio_pkg

// file: nio_port_top.sv
// nibble port set: apb register slave, pull-up groups, filter and pin drivers
// Functional notes
// - nibble a input only, pull-ups 3:1 grouped
// - noise filter only on nibble b bit0
// - nibbles d and g per-bit direction
// - nibble d pull-ups one four-bit group
// - nibbles b,c,g,h pull-ups grouped per nibble
// - pair i bidirectional, pull-ups grouped together
// - nibbles e,f open drain, pull low only
// - nibbles e,f released after reset
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module nio_port_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] input_nibble_a_in,
  output logic input_nibble_a_pu,
  input wire logic [3:0] input_nibble_b_in,
  output logic input_nibble_b_pu,
  output logic edge_irq_in_zero,
  input wire logic [3:0] io_nibble_c_in,
  output logic [3:0] io_nibble_c_out,
  output logic [3:0] io_nibble_c_oe,
  output logic io_nibble_c_pu,
  input wire logic [3:0] io_nibble_d_in,
  output logic [3:0] io_nibble_d_out,
  output logic [3:0] io_nibble_d_oe,
  output logic io_nibble_d_pu,
  input wire logic [3:0] opendrain_nibble_e_in,
  output logic [3:0] opendrain_nibble_e_out,
  output logic [3:0] opendrain_nibble_e_oe,
  input wire logic [3:0] opendrain_nibble_f_in,
  output logic [3:0] opendrain_nibble_f_out,
  output logic [3:0] opendrain_nibble_f_oe,
  input wire logic [3:0] io_nibble_g_in,
  output logic [3:0] io_nibble_g_out,
  output logic [3:0] io_nibble_g_oe,
  output logic io_nibble_g_pu,
  input wire logic [3:0] io_nibble_h_in,
  output logic [3:0] io_nibble_h_out,
  output logic [3:0] io_nibble_h_oe,
  output logic io_nibble_h_pu,
  input wire logic [1:0] io_pair_i_in,
  output logic [1:0] io_pair_i_out,
  output logic [1:0] io_pair_i_oe,
  output logic io_pair_i_pu
);
  logic rst_meta_reg;
  logic rst_sync_b_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [3:0] latch_c_reg;
  logic [3:0] latch_d_reg;
  logic [3:0] latch_e_reg;
  logic [3:0] latch_f_reg;
  logic [3:0] latch_g_reg;
  logic [3:0] latch_h_reg;
  logic [1:0] latch_i_reg;
  logic [nio_pkg::DIR_W-1:0] dir_reg;
  logic [nio_pkg::PU_W-1:0] pu_reg;
  logic filt_en_reg;
  logic irq_zero_reg;
  logic filt_clean;
  logic b0_level;
  logic setup_phase;
  logic wr_take;
  logic [31:0] rd_mux;
  logic [3:0] rd_c;
  logic [3:0] rd_d;
  logic [3:0] rd_e;
  logic [3:0] rd_f;
  logic [3:0] rd_g;
  logic [3:0] rd_h;
  logic [1:0] rd_i;
  logic [3:0] dir_c;
  logic [3:0] dir_h;
  logic [1:0] dir_i;

  // address match, shared by the write strobes and the read mux
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = addr == ofs;
  endfunction : hit

  function automatic logic mapped(input logic [7:0] addr);
    mapped = addr[1:0] == 2'h0 && addr <= nio_pkg::OFS_FILTER;
  endfunction : mapped

  // reset release through two flops; the first is read only by the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b_reg <= rst_meta_reg;
    end
  end

  // apb: ready one cycle after setup, a write lands only at that edge
  assign setup_phase = psel && !penable;
  assign wr_take = psel && penable && pready_reg && pwrite;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // nibble b bit0 reads through the filter only when it is selected
  assign b0_level = filt_en_reg ? filt_clean : input_nibble_b_in[0];

  // read selection; reserved bits read zero
  assign rd_mux = hit(paddr, nio_pkg::OFS_NIB_A) ? {28'h0000000, input_nibble_a_in} :
                  hit(paddr, nio_pkg::OFS_NIB_B) ? {28'h0000000, input_nibble_b_in[3:1], b0_level} :
                  hit(paddr, nio_pkg::OFS_NIB_C) ? {28'h0000000, rd_c} :
                  hit(paddr, nio_pkg::OFS_NIB_D) ? {28'h0000000, rd_d} :
                  hit(paddr, nio_pkg::OFS_NIB_E) ? {28'h0000000, rd_e} :
                  hit(paddr, nio_pkg::OFS_NIB_F) ? {28'h0000000, rd_f} :
                  hit(paddr, nio_pkg::OFS_NIB_G) ? {28'h0000000, rd_g} :
                  hit(paddr, nio_pkg::OFS_NIB_H) ? {28'h0000000, rd_h} :
                  hit(paddr, nio_pkg::OFS_PAIR_I) ? {30'h00000000, rd_i} :
                  hit(paddr, nio_pkg::OFS_DIR) ? {21'h000000, dir_reg} :
                  hit(paddr, nio_pkg::OFS_PULLUP) ? {25'h0000000, pu_reg} :
                  hit(paddr, nio_pkg::OFS_FILTER) ? {31'h00000000, filt_en_reg} :
                  32'h00000000;

  // bus answer registers: data is captured in setup and held over access
  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !mapped(paddr);
      if (setup_phase && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // output latches; open-drain latches start at one so the pins float
  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      latch_c_reg <= nio_pkg::RST_PP_LATCH;
      latch_d_reg <= nio_pkg::RST_PP_LATCH;
      latch_e_reg <= nio_pkg::RST_OD_LATCH;
      latch_f_reg <= nio_pkg::RST_OD_LATCH;
      latch_g_reg <= nio_pkg::RST_PP_LATCH;
      latch_h_reg <= nio_pkg::RST_PP_LATCH;
      latch_i_reg <= nio_pkg::RST_PAIR_LATCH;
    end else if (wr_take) begin
      if (hit(paddr, nio_pkg::OFS_NIB_C)) latch_c_reg <= pwdata[3:0];
      if (hit(paddr, nio_pkg::OFS_NIB_D)) latch_d_reg <= pwdata[3:0];
      if (hit(paddr, nio_pkg::OFS_NIB_E)) latch_e_reg <= pwdata[3:0];
      if (hit(paddr, nio_pkg::OFS_NIB_F)) latch_f_reg <= pwdata[3:0];
      if (hit(paddr, nio_pkg::OFS_NIB_G)) latch_g_reg <= pwdata[3:0];
      if (hit(paddr, nio_pkg::OFS_NIB_H)) latch_h_reg <= pwdata[3:0];
      if (hit(paddr, nio_pkg::OFS_PAIR_I)) latch_i_reg <= pwdata[1:0];
    end
  end

  // control registers: every pin comes up as input, pull-ups and filter off
  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      dir_reg <= nio_pkg::RST_DIR;
      pu_reg <= nio_pkg::RST_PULLUP;
      filt_en_reg <= nio_pkg::RST_FILT_EN;
    end else if (wr_take) begin
      if (hit(paddr, nio_pkg::OFS_DIR)) dir_reg <= pwdata[nio_pkg::DIR_W-1:0];
      if (hit(paddr, nio_pkg::OFS_PULLUP)) pu_reg <= pwdata[nio_pkg::PU_W-1:0];
      if (hit(paddr, nio_pkg::OFS_FILTER)) filt_en_reg <= pwdata[nio_pkg::FILT_EN_BIT];
    end
  end

  // one pull-up switch per group, driven straight from the control flops
  assign input_nibble_a_pu = pu_reg[nio_pkg::PU_A_BIT];
  assign input_nibble_b_pu = pu_reg[nio_pkg::PU_B_BIT];
  assign io_nibble_c_pu = pu_reg[nio_pkg::PU_C_BIT];
  assign io_nibble_d_pu = pu_reg[nio_pkg::PU_D_BIT];
  assign io_nibble_g_pu = pu_reg[nio_pkg::PU_G_BIT];
  assign io_nibble_h_pu = pu_reg[nio_pkg::PU_H_BIT];
  assign io_pair_i_pu = pu_reg[nio_pkg::PU_I_BIT];

  // whole-port direction for c, h and i fans one bit out to every pin
  assign dir_c = {4{dir_reg[nio_pkg::DIR_C_BIT]}};
  assign dir_h = {4{dir_reg[nio_pkg::DIR_H_BIT]}};
  assign dir_i = {2{dir_reg[nio_pkg::DIR_I_BIT]}};

  // filtered interrupt level; the filter sits only on this one pin
  nio_noise_filter u_filt (
    .clk_sys(clk_sys),
    .rst_sync_b(rst_sync_b_reg),
    .raw_in(input_nibble_b_in[0]),
    .clean_out(filt_clean)
  );

  // interrupt level registered; switching the filter in costs its window of latency
  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      irq_zero_reg <= 1'b0;
    end else begin
      irq_zero_reg <= b0_level;
    end
  end
  assign edge_irq_in_zero = irq_zero_reg;

  // push-pull ports
  nio_pin_group #(.W(4), .OPEN_DRAIN(1'b0)) u_c (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_c_reg), .dir(dir_c),
    .pin_in(io_nibble_c_in), .pin_out(io_nibble_c_out), .pin_oe(io_nibble_c_oe), .rd_val(rd_c)
  );
  nio_pin_group #(.W(4), .OPEN_DRAIN(1'b0)) u_d (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_d_reg),
    .dir(dir_reg[nio_pkg::DIR_D_LSB +: 4]),
    .pin_in(io_nibble_d_in), .pin_out(io_nibble_d_out), .pin_oe(io_nibble_d_oe), .rd_val(rd_d)
  );
  nio_pin_group #(.W(4), .OPEN_DRAIN(1'b0)) u_g (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_g_reg),
    .dir(dir_reg[nio_pkg::DIR_G_LSB +: 4]),
    .pin_in(io_nibble_g_in), .pin_out(io_nibble_g_out), .pin_oe(io_nibble_g_oe), .rd_val(rd_g)
  );
  nio_pin_group #(.W(4), .OPEN_DRAIN(1'b0)) u_h (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_h_reg), .dir(dir_h),
    .pin_in(io_nibble_h_in), .pin_out(io_nibble_h_out), .pin_oe(io_nibble_h_oe), .rd_val(rd_h)
  );
  nio_pin_group #(.W(2), .OPEN_DRAIN(1'b0)) u_i (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_i_reg), .dir(dir_i),
    .pin_in(io_pair_i_in), .pin_out(io_pair_i_out), .pin_oe(io_pair_i_oe), .rd_val(rd_i)
  );

  // open-drain ports never drive high; pull-ups are off-chip
  nio_pin_group #(.W(4), .OPEN_DRAIN(1'b1)) u_e (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_e_reg), .dir(4'h0),
    .pin_in(opendrain_nibble_e_in), .pin_out(opendrain_nibble_e_out),
    .pin_oe(opendrain_nibble_e_oe), .rd_val(rd_e)
  );
  nio_pin_group #(.W(4), .OPEN_DRAIN(1'b1)) u_f (
    .clk_sys(clk_sys), .rst_sync_b(rst_sync_b_reg), .latch(latch_f_reg), .dir(4'h0),
    .pin_in(opendrain_nibble_f_in), .pin_out(opendrain_nibble_f_out),
    .pin_oe(opendrain_nibble_f_oe), .rd_val(rd_f)
  );

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b_reg);

  AST_PU_A_GROUP: assert property (
    wr_take && hit(paddr, nio_pkg::OFS_PULLUP) |=> input_nibble_a_pu == $past(pwdata[0]))
    else $error("nibble a pull-up group did not follow its write");

  AST_FILTER_BYPASS: assert property (
    !filt_en_reg && !$past(filt_en_reg) |=> edge_irq_in_zero == $past(input_nibble_b_in[0]))
    else $error("unfiltered interrupt level did not follow the pin");

  // a pulse one cycle shorter than the window, with a settled low before it, must die
  AST_FILTER_GLITCH: assert property (
    filt_en_reg && filt_clean == 1'b0 && !input_nibble_b_in[0] ##1 input_nibble_b_in[0] [*3]
    ##1 !input_nibble_b_in[0] |=> filt_clean == 1'b0)
    else $error("a three-cycle pulse passed the noise filter");

  AST_DIR_PER_BIT: assert property (
    wr_take && hit(paddr, nio_pkg::OFS_DIR) |-> ##2
    (io_nibble_d_oe == $past(pwdata[3:0], 2) && io_nibble_g_oe == $past(pwdata[7:4], 2)))
    else $error("per-bit direction not applied two cycles after write");

  AST_PU_D_GROUP: assert property (
    wr_take && hit(paddr, nio_pkg::OFS_PULLUP) |=> io_nibble_d_pu == $past(pwdata[3]))
    else $error("nibble d pull-up group wrong");

  AST_PU_NIBBLE_GROUPS: assert property (
    wr_take && hit(paddr, nio_pkg::OFS_PULLUP) |=>
    {io_nibble_h_pu, io_nibble_g_pu, io_nibble_c_pu, input_nibble_b_pu}
    == {$past(pwdata[5]), $past(pwdata[4]), $past(pwdata[2]), $past(pwdata[1])})
    else $error("nibble pull-up groups wrong");

  AST_PAIR_TOGETHER: assert property (
    (io_pair_i_oe[0] == io_pair_i_oe[1]) and (wr_take && hit(paddr, nio_pkg::OFS_PULLUP)
    |=> io_pair_i_pu == $past(pwdata[6])))
    else $error("pair i direction or pull-up not grouped");

  AST_OD_LOW_ONLY: assert property (
    opendrain_nibble_e_out == 4'h0 && opendrain_nibble_f_out == 4'h0
    && opendrain_nibble_e_oe == ~$past(latch_e_reg))
    else $error("open-drain port drove high or ignored its latch");

  AST_OD_RELEASED: assert property (
    $rose(rst_sync_b_reg) |-> opendrain_nibble_e_oe == 4'h0 && opendrain_nibble_f_oe == 4'h0)
    else $error("open-drain pins not released after reset");

  AST_INPUTS_AFTER_RESET: assert property (
    $rose(rst_sync_b_reg) |-> (io_nibble_c_oe | io_nibble_d_oe | io_nibble_g_oe
    | io_nibble_h_oe) == 4'h0 && io_pair_i_oe == 2'h0)
    else $error("push-pull pins not inputs after reset");

endmodule : nio_port_top

// file: test_nibble_io_port_set.sv
// self-checking bench for the nibble port set with a board model on its pins
`timescale 1ns/100ps
module test_nibble_io_port_set;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, errv, seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] input_nibble_a_in, input_nibble_b_in, io_nibble_c_in, io_nibble_d_in;
  logic [3:0] opendrain_nibble_e_in, opendrain_nibble_f_in, io_nibble_g_in, io_nibble_h_in;
  logic [3:0] io_nibble_c_out, io_nibble_c_oe, io_nibble_d_out, io_nibble_d_oe;
  logic [3:0] opendrain_nibble_e_out, opendrain_nibble_e_oe;
  logic [3:0] opendrain_nibble_f_out, opendrain_nibble_f_oe;
  logic [3:0] io_nibble_g_out, io_nibble_g_oe, io_nibble_h_out, io_nibble_h_oe;
  logic [1:0] io_pair_i_in, io_pair_i_out, io_pair_i_oe;
  logic input_nibble_a_pu, input_nibble_b_pu, io_nibble_c_pu, io_nibble_d_pu;
  logic io_nibble_g_pu, io_nibble_h_pu, io_pair_i_pu, edge_irq_in_zero;
  logic [33:0] ext_val, ext_en, pin_lvl, oe_all, out_all, pu_all;
  logic [6:0] pu_vec;
  logic [7:0] offs [7];
  int fails, n_checks;

  nio_port_top dut_u (.*);

  // pin vector: i 33:32, h, g, f, e, d, c, b, a 3:0
  assign oe_all = {io_pair_i_oe, io_nibble_h_oe, io_nibble_g_oe, opendrain_nibble_f_oe,
                   opendrain_nibble_e_oe, io_nibble_d_oe, io_nibble_c_oe, 8'h00};
  assign out_all = {io_pair_i_out, io_nibble_h_out, io_nibble_g_out, opendrain_nibble_f_out,
                    opendrain_nibble_e_out, io_nibble_d_out, io_nibble_c_out, 8'h00};
  assign pu_all = {{2{io_pair_i_pu}}, {4{io_nibble_h_pu}}, {4{io_nibble_g_pu}}, 8'h00,
                   {4{io_nibble_d_pu}}, {4{io_nibble_c_pu}}, {4{input_nibble_b_pu}},
                   {3{input_nibble_a_pu}}, 1'b0};
  assign pu_vec = {io_pair_i_pu, io_nibble_h_pu, io_nibble_g_pu, io_nibble_d_pu,
                   io_nibble_c_pu, input_nibble_b_pu, input_nibble_a_pu};
  assign {io_pair_i_in, io_nibble_h_in, io_nibble_g_in, opendrain_nibble_f_in,
          opendrain_nibble_e_in, io_nibble_d_in, io_nibble_c_in, input_nibble_b_in,
          input_nibble_a_in} = pin_lvl;

  // open-drain nibbles e and f carry board pull-ups
  nio_board_model #(.W(34), .OD_MASK(34'h000FF0000), .BOARD_PU(34'h000FF0000)) brd_u (
    .clk_sys(clk_sys), .drv_out(out_all), .drv_oe(oe_all), .chip_pu(pu_all),
    .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge; psel drops for a cycle after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 34'h1, 34'h0);
    @(posedge clk_sys);
  endtask : apb

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(nm, {2'h0, exp}, {2'h0, rdv});
  endtask : rd_chk

  // drive nibble b bit 0 high for len cycles and note whether the irq line rises
  task automatic pulse(input int len);
    seen = 1'b0;
    ext_val[4] <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_sys);
      if (c == len - 1) ext_val[4] <= 1'b0;
      if (edge_irq_in_zero === 1'b1) seen = 1'b1;
    end
    repeat (8) @(posedge clk_sys);
  endtask : pulse

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    $display("Error watchdog expected end seen timeout");
    final_report();
  end

  initial begin
    offs = '{nio_pkg::OFS_NIB_A, nio_pkg::OFS_NIB_B, nio_pkg::OFS_NIB_C, nio_pkg::OFS_NIB_D,
             nio_pkg::OFS_NIB_G, nio_pkg::OFS_NIB_H, nio_pkg::OFS_PAIR_I};
    fails = 0;
    n_checks = 0;
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext_val = '0;
    ext_en = '0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // state after reset: nothing driven, pull-ups off, open-drain released
    chk("oe reset", 34'h0, oe_all);
    chk("pu reset", 34'h0, {27'h0, pu_vec});
    rd_chk("dir reset", nio_pkg::OFS_DIR, {21'h0, nio_pkg::RST_DIR});
    rd_chk("pullup reset", nio_pkg::OFS_PULLUP, {25'h0, nio_pkg::RST_PULLUP});
    rd_chk("filter reset", nio_pkg::OFS_FILTER, 32'h00000000);
    rd_chk("e released", nio_pkg::OFS_NIB_E, 32'h0000000F);
    rd_chk("f released", nio_pkg::OFS_NIB_F, 32'h0000000F);
    // each pull-up group alone, then all groups pulling floating pins high
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, nio_pkg::OFS_PULLUP, 32'h1 << k);
      chk("pu group", 34'h1 << k, {27'h0, pu_vec});
    end
    apb(1'b1, nio_pkg::OFS_PULLUP, 32'h0000007F);
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, offs[k], 32'h00000000);
      chk("pulled pins", (k == 0) ? 34'hE : (k == 6) ? 34'h3 : 34'hF,
          {30'h0, rdv[3:0]} & ((k == 0) ? 34'hE : 34'hF));
    end
    // per-bit direction on d and g, board holding their inputs low
    apb(1'b1, nio_pkg::OFS_PULLUP, 32'h00000000);
    ext_en <= 34'h00F00F000;
    apb(1'b1, nio_pkg::OFS_NIB_D, 32'h0000000F);
    apb(1'b1, nio_pkg::OFS_NIB_G, 32'h0000000F);
    apb(1'b1, nio_pkg::OFS_DIR, 32'h000000A5);
    repeat (3) @(posedge clk_sys);
    chk("d oe", 34'h5, {30'h0, io_nibble_d_oe});
    chk("g oe", 34'hA, {30'h0, io_nibble_g_oe});
    chk("d g out", 34'hFF, {26'h0, io_nibble_d_out, io_nibble_g_out});
    chk("c h i oe", 34'h0, {24'h0, io_pair_i_oe, io_nibble_h_oe, io_nibble_c_oe});
    rd_chk("d mixed", nio_pkg::OFS_NIB_D, 32'h00000005);
    rd_chk("g mixed", nio_pkg::OFS_NIB_G, 32'h0000000A);
    apb(1'b1, nio_pkg::OFS_NIB_C, 32'h00000009);
    apb(1'b1, nio_pkg::OFS_PAIR_I, 32'h00000002);
    apb(1'b1, nio_pkg::OFS_DIR, 32'h00000700);
    repeat (3) @(posedge clk_sys);
    chk("c h i oe", 34'h3FF, {24'h0, io_nibble_c_oe, io_nibble_h_oe, io_pair_i_oe});
    chk("c h i out", 34'h242, {24'h0, io_nibble_c_out, io_nibble_h_out, io_pair_i_out});
    chk("d oe off", 34'h0, {30'h0, io_nibble_d_oe});
    // open-drain nibbles sink on zero bits and read the pins back
    apb(1'b1, nio_pkg::OFS_NIB_E, 32'h00000005);
    apb(1'b1, nio_pkg::OFS_NIB_F, 32'h00000003);
    repeat (3) @(posedge clk_sys);
    chk("e sink", 34'hA0, {26'h0, opendrain_nibble_e_oe, opendrain_nibble_e_out});
    chk("f sink", 34'hC0, {26'h0, opendrain_nibble_f_oe, opendrain_nibble_f_out});
    rd_chk("e pins", nio_pkg::OFS_NIB_E, 32'h00000005);
    rd_chk("f pins", nio_pkg::OFS_NIB_F, 32'h00000003);
    // read-only write is quietly ignored, an unmapped place is refused
    apb(1'b1, nio_pkg::OFS_NIB_A, 32'h0000000F);
    chk("ro write err", 34'h0, {33'h0, errv});
    apb(1'b0, 8'h30, 32'h00000000);
    chk("unmapped err", 34'h1, {33'h0, errv});
    // short glitch passes unfiltered, is removed once the filter is on
    ext_en[4] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    pulse(2);
    chk("unfiltered", 34'h1, {33'h0, seen});
    apb(1'b1, nio_pkg::OFS_FILTER, 32'h00000001);
    pulse(3);
    chk("glitch blocked", 34'h0, {33'h0, seen});
    pulse(10);
    chk("long level", 34'h1, {33'h0, seen});
    // second reset with drivers active must release everything
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("oe in reset", 34'h0, oe_all);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("oe after reset", 34'h0, oe_all);
    rd_chk("dir again", nio_pkg::OFS_DIR, 32'h00000000);
    rd_chk("e again", nio_pkg::OFS_NIB_E, 32'h0000000F);
    final_report();
  end
endmodule : test_nibble_io_port_set
